/* timer0_pkg.sv */
// Constants and types shared by the timer counter core
`default_nettype none
package timer0_pkg;
  // Register byte offsets
  localparam logic [7:0] CONTROL_A_OFFSET = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET   = 8'h04;
  localparam logic [7:0] COUNTER_OFFSET   = 8'h08;
  localparam logic [7:0] COMPARE_OFFSET   = 8'h0c;
  localparam logic [7:0] FLAG_OFFSET      = 8'h10;
  localparam logic [7:0] MASK_OFFSET      = 8'h14;
  localparam logic [7:0] ASYNC_OFFSET     = 8'h18;

  // Field positions
  localparam int OVERFLOW_BIT = 0;
  localparam int COMPARE_BIT  = 1;
  localparam int ASYNC_BIT    = 0;

  // Counter landmarks and reset values
  localparam logic [7:0] BOTTOM_VALUE  = 8'h00;
  localparam logic [7:0] MAX_VALUE     = 8'hff;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [2:0] SELECT_RESET  = 3'h0;
  localparam logic [1:0] FLAG_RESET    = 2'h0;
  localparam logic [1:0] MASK_RESET    = 2'h0;

  // Prescaler masks per clock source select code; code 0 is stopped
  localparam logic [7:0][9:0] PRESCALE_MASK = {
    10'h3ff, 10'h0ff, 10'h07f, 10'h03f, 10'h01f, 10'h007, 10'h000, 10'h000
  };

  typedef enum logic [1:0] {
    MODE_NORMAL    = 2'h0,
    MODE_PHASE_PWM = 2'h1,
    MODE_CTC       = 2'h2,
    MODE_FAST_PWM  = 2'h3
  } waveform_mode_t;
endpackage : timer0_pkg
`default_nettype wire

/* tick_if.sv */
// Tick source control and tick strobe between core and tick generator
`default_nettype none
interface tick_if;
  logic [2:0] clock_source_select;
  logic       async_clock_select;
  logic       tick;
  modport src  (input clock_source_select, input async_clock_select, output tick);
  modport sink (output clock_source_select, output async_clock_select, input tick);
endinterface : tick_if
`default_nettype wire

/* timer0_tick_gen.sv */
// Timer tick generator: crystal synchroniser and 10-bit prescaler
`default_nettype none
module timer0_tick_gen (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic crystal_in_pin,
  tick_if.src       ctl
);
  typedef struct packed {
    logic       xtal_meta;
    logic       xtal_sync;
    logic       xtal_prev;
    logic [9:0] prescale;
    logic       tick;
  } gen_state_t;

  gen_state_t s;
  gen_state_t next_s;
  logic       source_event;
  logic [9:0] sel_mask;

  always_comb begin
    next_s = s;
    next_s.xtal_meta = crystal_in_pin;
    next_s.xtal_sync = s.xtal_meta;
    next_s.xtal_prev = s.xtal_sync;
    sel_mask = timer0_pkg::PRESCALE_MASK[ctl.clock_source_select];
    // Crystal rising edge or every io clock
    source_event = ctl.async_clock_select ? (s.xtal_sync & ~s.xtal_prev) : 1'b1;
    next_s.tick = 1'b0;
    if (ctl.clock_source_select == 3'h0) begin
      next_s.prescale = 10'h000;
    end else if (source_event) begin
      next_s.tick     = (s.prescale & sel_mask) == sel_mask;
      next_s.prescale = s.prescale + 10'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ctl.tick = s.tick;
endmodule : timer0_tick_gen
`default_nettype wire

/* timer0_core.sv */
// Timer counter core with AHB-Lite register slave
`default_nettype none
// Operation
// - Counter and compare registers are eight bits wide.
// - Each request shows as a flag bit and is gated by its mask bit.
// - Clock source select zero stops ticks; counter stays still.
// - Ticks come from io clock, or crystal pin when async select set.
// - Active compare value is compared continuously; match sets compare flag.
// - Bottom at 0x00, max at 0xff; top is 0xff or compare by mode.
// - Each tick without a counter write does exactly one of clear, increment or decrement.
// - Counter reads and writes work whether ticks run or not.
// - Software counter write beats clear or count in the same cycle.
// - Waveform mode bits in control A choose the counting sequence.
// - Overflow flag set point depends on mode; it can raise interrupt.
// - Compare flag set on the tick after match; cleared by read or one.
// - Normal mode counts up, wraps 0xff to 0x00, overflow on wrap.
// - CTC mode clears counter on compare match; compare is top.
// - Counter write blocks compare match on the next tick, even stopped.
module timer0_core (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        crystal_in_pin,
  output logic             irq,
  output logic             counter_bottom,
  output logic             counter_max,
  output logic             compare_match
);
  typedef struct packed {
    logic                      wr_pend;
    logic [7:0]                wr_addr;
    logic [31:0]               rdata;
    timer0_pkg::waveform_mode_t waveform_mode;
    logic [2:0]                clock_source_select;
    logic                      async_clock_select;
    logic [7:0]                counter_value;
    logic [7:0]                compare_buffer;
    logic [7:0]                compare_value;
    logic                      count_down;
    logic                      block_match;
    logic [1:0]                flags;
    logic [1:0]                mask;
  } core_state_t;

  core_state_t s;
  core_state_t next_s;
  logic        tick;
  logic        addr_phase;
  logic        cnt_wr;
  logic        match;
  logic        count_en;
  logic [1:0]  flag_set;
  logic [1:0]  flag_clr;
  logic [31:0] rd_word;

  tick_if tick_ctl ();

  timer0_tick_gen u_tick_gen (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .crystal_in_pin (crystal_in_pin),
    .ctl            (tick_ctl.src)
  );

  assign tick_ctl.clock_source_select = s.clock_source_select;
  assign tick_ctl.async_clock_select  = s.async_clock_select;
  assign tick = tick_ctl.tick;

  assign addr_phase = hsel & hready & htrans[1];
  assign cnt_wr     = s.wr_pend && (s.wr_addr == timer0_pkg::COUNTER_OFFSET);
  assign match      = s.counter_value == s.compare_value;
  assign count_en   = tick && !cnt_wr;

  always_comb begin
    next_s   = s;
    flag_set = 2'h0;
    flag_clr = 2'h0;
    rd_word  = 32'h0000_0000;

    // Address phase: latch write, capture read data
    next_s.wr_pend = addr_phase & hwrite;
    next_s.wr_addr = haddr[7:0];
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        timer0_pkg::CONTROL_A_OFFSET: rd_word[1:0] = s.waveform_mode;
        timer0_pkg::CONTROL_OFFSET:   rd_word[2:0] = s.clock_source_select;
        timer0_pkg::COUNTER_OFFSET:   rd_word[7:0] = s.counter_value;
        timer0_pkg::COMPARE_OFFSET:   rd_word[7:0] = s.compare_buffer;
        timer0_pkg::FLAG_OFFSET: begin
          rd_word[1:0] = s.flags;
          flag_clr     = s.flags;
        end
        timer0_pkg::MASK_OFFSET:      rd_word[1:0] = s.mask;
        timer0_pkg::ASYNC_OFFSET:     rd_word[timer0_pkg::ASYNC_BIT] = s.async_clock_select;
        default:                      rd_word = 32'h0000_0000;
      endcase
      next_s.rdata = rd_word;
    end

    // Counting on tick unless software writes the counter
    if (tick && !cnt_wr) begin
      next_s.block_match = 1'b0;
      if (match && !s.block_match) begin
        flag_set[timer0_pkg::COMPARE_BIT] = 1'b1;
      end
      unique case (s.waveform_mode)
        timer0_pkg::MODE_NORMAL: begin
          next_s.counter_value = s.counter_value + 8'h01;
          if (s.counter_value == timer0_pkg::MAX_VALUE) begin
            flag_set[timer0_pkg::OVERFLOW_BIT] = 1'b1;
          end
        end
        timer0_pkg::MODE_CTC: begin
          if (match) begin
            next_s.counter_value = timer0_pkg::BOTTOM_VALUE;
          end else begin
            next_s.counter_value = s.counter_value + 8'h01;
          end
          if (s.counter_value == timer0_pkg::MAX_VALUE) begin
            flag_set[timer0_pkg::OVERFLOW_BIT] = 1'b1;
          end
        end
        timer0_pkg::MODE_FAST_PWM: begin
          next_s.counter_value = s.counter_value + 8'h01;
          if (s.counter_value == timer0_pkg::MAX_VALUE) begin
            flag_set[timer0_pkg::OVERFLOW_BIT] = 1'b1;
            next_s.compare_value = s.compare_buffer;
          end
        end
        timer0_pkg::MODE_PHASE_PWM: begin
          if (!s.count_down) begin
            if (s.counter_value == timer0_pkg::MAX_VALUE) begin
              next_s.count_down    = 1'b1;
              next_s.counter_value = s.counter_value - 8'h01;
              next_s.compare_value = s.compare_buffer;
            end else begin
              next_s.counter_value = s.counter_value + 8'h01;
            end
          end else if (s.counter_value == timer0_pkg::BOTTOM_VALUE) begin
            next_s.count_down    = 1'b0;
            next_s.counter_value = s.counter_value + 8'h01;
            flag_set[timer0_pkg::OVERFLOW_BIT] = 1'b1;
          end else begin
            next_s.counter_value = s.counter_value - 8'h01;
          end
        end
      endcase
    end

    // Data phase: register writes
    if (s.wr_pend) begin
      unique case (s.wr_addr)
        timer0_pkg::CONTROL_A_OFFSET: begin
          next_s.waveform_mode = timer0_pkg::waveform_mode_t'(hwdata[1:0]);
          next_s.count_down    = 1'b0;
        end
        timer0_pkg::CONTROL_OFFSET: next_s.clock_source_select = hwdata[2:0];
        timer0_pkg::COUNTER_OFFSET: begin
          next_s.counter_value = hwdata[7:0];
          next_s.block_match   = 1'b1;
        end
        timer0_pkg::COMPARE_OFFSET: begin
          next_s.compare_buffer = hwdata[7:0];
          // Buffering only in the PWM modes
          if (s.waveform_mode == timer0_pkg::MODE_NORMAL ||
              s.waveform_mode == timer0_pkg::MODE_CTC) begin
            next_s.compare_value = hwdata[7:0];
          end
        end
        timer0_pkg::FLAG_OFFSET: flag_clr = flag_clr | hwdata[1:0];
        timer0_pkg::MASK_OFFSET: next_s.mask = hwdata[1:0];
        timer0_pkg::ASYNC_OFFSET: begin
          next_s.async_clock_select = hwdata[timer0_pkg::ASYNC_BIT];
        end
        default: next_s.mask = s.mask;
      endcase
    end

    // Set wins over clear
    next_s.flags = (s.flags & ~flag_clr) | flag_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{
        wr_pend:             1'b0,
        wr_addr:             8'h00,
        rdata:               32'h0000_0000,
        waveform_mode:       timer0_pkg::MODE_NORMAL,
        clock_source_select: timer0_pkg::SELECT_RESET,
        async_clock_select:  1'b0,
        counter_value:       timer0_pkg::COUNTER_RESET,
        compare_buffer:      timer0_pkg::COMPARE_RESET,
        compare_value:       timer0_pkg::COMPARE_RESET,
        count_down:          1'b0,
        block_match:         1'b0,
        flags:               timer0_pkg::FLAG_RESET,
        mask:                timer0_pkg::MASK_RESET
      };
    end else begin
      s <= next_s;
    end
  end

  assign hrdata         = s.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign irq            = |(s.flags & s.mask);
  assign counter_bottom = s.counter_value == timer0_pkg::BOTTOM_VALUE;
  assign counter_max    = s.counter_value == timer0_pkg::MAX_VALUE;
  assign compare_match  = match;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_count_tick;
    tick && !cnt_wr;
  endsequence

  sequence s_stopped_two;
    (s.clock_source_select == 3'h0) ##1 (s.clock_source_select == 3'h0);
  endsequence

  sequence s_counter_write;
    cnt_wr;
  endsequence

  property p_stopped_no_tick;
    s_stopped_two |-> !tick;
  endproperty

  AST_STOPPED_NO_TICK: assert property (p_stopped_no_tick)
    else $error("tick seen with clock source stopped");

  AST_WRITE_PRIORITY: assert property (
    s_counter_write |=> s.counter_value == $past(hwdata[7:0]))
    else $error("counter write lost to count");

  AST_BLOCK_NEXT_TICK: assert property (
    s_counter_write ##1 (!s.flags[timer0_pkg::COMPARE_BIT] && count_en)
      |=> !s.flags[timer0_pkg::COMPARE_BIT])
    else $error("compare match not blocked after counter write");

  AST_COMPARE_SET: assert property (
    (s_count_tick ##0 (match && !s.block_match))
      |=> s.flags[timer0_pkg::COMPARE_BIT])
    else $error("compare flag not set on tick after match");

  AST_NORMAL_WRAP: assert property (
    (s.waveform_mode == timer0_pkg::MODE_NORMAL && count_en &&
     s.counter_value == timer0_pkg::MAX_VALUE)
      |=> counter_bottom && s.flags[timer0_pkg::OVERFLOW_BIT])
    else $error("normal mode wrap or overflow wrong");

  AST_CTC_CLEAR: assert property (
    (s.waveform_mode == timer0_pkg::MODE_CTC && count_en && match)
      |=> counter_bottom)
    else $error("ctc mode did not clear on match");

  AST_IRQ_GATE: assert property (
    (s.flags[timer0_pkg::OVERFLOW_BIT] && !s.mask[timer0_pkg::OVERFLOW_BIT] &&
     !(s.flags[timer0_pkg::COMPARE_BIT] && s.mask[timer0_pkg::COMPARE_BIT])) |-> !irq)
    else $error("masked flag raised interrupt");

  AST_NORMAL_STEP: assert property (
    (s.waveform_mode == timer0_pkg::MODE_NORMAL && count_en)
      |=> s.counter_value == 8'($past(s.counter_value) + 8'h01))
    else $error("normal mode did not step by one");

  AST_HOLD_NO_TICK: assert property (
    (!tick && !cnt_wr) |=> $stable(s.counter_value))
    else $error("counter moved without tick");

  AST_COUNTER_READ: assert property (
    (addr_phase && !hwrite && haddr[7:0] == timer0_pkg::COUNTER_OFFSET)
      |=> hrdata[7:0] == $past(s.counter_value))
    else $error("counter read data wrong");

  AST_SET_WINS: assert property (
    (count_en && match && !s.block_match && addr_phase && !hwrite &&
     haddr[7:0] == timer0_pkg::FLAG_OFFSET) |=> s.flags[timer0_pkg::COMPARE_BIT])
    else $error("compare flag lost to read clear");

  AST_STOPPED_HOLD: assert property (
    (s_stopped_two ##0 !cnt_wr) |=> $stable(s.counter_value))
    else $error("counter moved with clock source stopped");

  AST_PHASE_TURN: assert property (
    (s.waveform_mode == timer0_pkg::MODE_PHASE_PWM && count_en && !s.count_down &&
     s.counter_value == timer0_pkg::MAX_VALUE)
      |=> s.counter_value == 8'(timer0_pkg::MAX_VALUE - 8'h01))
    else $error("phase pwm did not turn down at max");

  AST_READ_CLEARS: assert property (
    (addr_phase && !hwrite && haddr[7:0] == timer0_pkg::FLAG_OFFSET && !count_en)
      |=> s.flags == 2'h0)
    else $error("flag read did not clear flags");

  AST_WRITE_ONE_CLEAR: assert property (
    (s.wr_pend && s.wr_addr == timer0_pkg::FLAG_OFFSET &&
     hwdata[timer0_pkg::COMPARE_BIT] && !count_en)
      |=> !s.flags[timer0_pkg::COMPARE_BIT])
    else $error("write one did not clear compare flag");
endmodule : timer0_core
`default_nettype wire

/* crystal_model.sv */
// Crystal oscillator model driving the timer crystal input
`default_nettype none
module crystal_model #(
  parameter int HALF_NS = 37
) (
  input  wire logic run,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    pin = 1'b0;
    forever begin
      #HALF_NS;
      // Oscillation only while enabled; rests low otherwise
      pin = run ? ~pin : 1'b0;
    end
  end
endmodule : crystal_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the timer counter core over AHB-Lite
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        counter_bottom, counter_max, compare_match, crystal_in_pin, crystal_run;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          n_fail, tests_run;
  int          div [7] = '{1, 8, 32, 64, 128, 256, 1024};
  logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};

  timer0_core dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .crystal_in_pin(crystal_in_pin), .irq(irq),
    .counter_bottom(counter_bottom), .counter_max(counter_max),
    .compare_match(compare_match)
  );

  crystal_model partner_u (.run(crystal_run), .pin(crystal_in_pin));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic print_verdict;
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask : idle

  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) n_fail++;
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd,
                     output logic [31:0] data);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, off};
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    data = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, off, d, x);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] off, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, off, 32'h0, x);
    chk(what, exp, x);
  endtask : rd_chk

  task automatic run_ticks(input logic [31:0] sel, input int n);
    wr(timer0_pkg::CONTROL_OFFSET, sel);
    idle(n);
    wr(timer0_pkg::CONTROL_OFFSET, 32'h0);
    bus(1'b0, timer0_pkg::COUNTER_OFFSET, 32'h0, rd);
  endtask : run_ticks

  initial begin
    repeat (30000) @(posedge hclk);
    n_fail++;
    print_verdict;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    crystal_run = 1'b0;
    n_fail = 0;
    tests_run = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    chk("bottom after reset", 32'h1, {31'h0, counter_bottom});
    chk("match after reset", 32'h1, {31'h0, compare_match});
    foreach (offs[i]) rd_chk("reset value", offs[i], 32'h0);
    wr(timer0_pkg::COUNTER_OFFSET, 32'h1ab);
    idle(20);
    rd_chk("stopped counter", timer0_pkg::COUNTER_OFFSET, 32'hab);
    wr(timer0_pkg::COUNTER_OFFSET, 32'hff);
    idle(2);
    chk("max", 32'h1, {31'h0, counter_max});
    chk("bottom", 32'h0, {31'h0, counter_bottom});
    chk("no match", 32'h0, {31'h0, compare_match});
    chk("response", 32'h0, {31'h0, hresp});
    // Prescaler divisions in normal mode
    for (int s = 1; s < 8; s++) begin
      wr(timer0_pkg::COUNTER_OFFSET, 32'h0);
      run_ticks(s, 64);
      chk("prescaled count", 32'h1, {31'h0, rd <= 70 / div[s-1] + 1 &&
          rd + 1 >= 64 / div[s-1] && (s > 1 || rd >= 60)});
    end
    // Normal mode wrap and overflow interrupt
    wr(timer0_pkg::COMPARE_OFFSET, 32'h80);
    wr(timer0_pkg::MASK_OFFSET, 32'h1);
    wr(timer0_pkg::COUNTER_OFFSET, 32'hfd);
    wr(timer0_pkg::CONTROL_OFFSET, 32'h1);
    for (int k = 0; k < 40 && irq !== 1'b1; k++) @(posedge hclk);
    chk("overflow irq", 32'h1, {31'h0, irq});
    run_ticks(32'h0, 0);
    chk("wrapped counter", 32'h0, {30'h0, rd[7:6]});
    rd_chk("overflow flag", timer0_pkg::FLAG_OFFSET, 32'h1);
    rd_chk("flags after read", timer0_pkg::FLAG_OFFSET, 32'h0);
    chk("irq after clear", 32'h0, {31'h0, irq});
    // Clear on compare mode
    wr(timer0_pkg::COUNTER_OFFSET, 32'h0);
    wr(timer0_pkg::CONTROL_A_OFFSET, 32'h2);
    wr(timer0_pkg::COMPARE_OFFSET, 32'h5);
    run_ticks(32'h1, 40);
    chk("ctc top", 32'h1, {31'h0, rd <= 32'h5});
    rd_chk("ctc flags", timer0_pkg::FLAG_OFFSET, 32'h2);
    run_ticks(32'h1, 20);
    wr(timer0_pkg::FLAG_OFFSET, 32'h2);
    rd_chk("flag after write one", timer0_pkg::FLAG_OFFSET, 32'h0);
    // Match blocked after counter write, or seen when passing through
    wr(timer0_pkg::CONTROL_A_OFFSET, 32'h0);
    wr(timer0_pkg::MASK_OFFSET, 32'h2);
    for (int i = 0; i < 2; i++) begin
      wr(timer0_pkg::COMPARE_OFFSET, 32'h40);
      wr(timer0_pkg::COUNTER_OFFSET, i ? 32'h3e : 32'h40);
      run_ticks(32'h1, 10);
      chk("compare irq", i, {31'h0, irq});
      rd_chk("compare flag", timer0_pkg::FLAG_OFFSET, i ? 32'h2 : 32'h0);
    end
    // Phase correct turns down at max; fast PWM wraps
    for (int m = 1; m < 4; m += 2) begin
      wr(timer0_pkg::COUNTER_OFFSET, 32'hfc);
      wr(timer0_pkg::CONTROL_A_OFFSET, m);
      run_ticks(32'h1, 8);
      chk("pwm sequence", 32'h1,
          {31'h0, m == 1 ? rd < 32'hfc && rd > 32'hf0 : rd < 32'h10});
    end
    // Crystal clocked counting
    wr(timer0_pkg::CONTROL_A_OFFSET, 32'h0);
    wr(timer0_pkg::ASYNC_OFFSET, 32'h1);
    wr(timer0_pkg::COUNTER_OFFSET, 32'h0);
    wr(timer0_pkg::CONTROL_OFFSET, 32'h1);
    crystal_run <= 1'b1;
    idle(60);
    crystal_run <= 1'b0;
    run_ticks(32'h1, 20);
    chk("crystal count", 32'h1, {31'h0, rd != 32'h0 && rd < 32'h10});
    wr(timer0_pkg::COUNTER_OFFSET, 32'h33);
    crystal_run <= 1'b1;
    idle(60);
    crystal_run <= 1'b0;
    rd_chk("no select with crystal", timer0_pkg::COUNTER_OFFSET, 32'h33);
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
